// file: core/cwpvu_pkg.sv
// constants, types and register map of the core wait unit
// assumes a single 250 MHz system clock and an apb master on the bus
// Function
// - pin-equal wait stalls until selected port bits and mask equal state
// - pin-not-equal wait stalls until masked bits differ from state
// - mask one monitors a pin, zero forces that position to zero
// - one-bit port select, zero first port, one second port
// - only first port exists, second port reads as all zero
// - pin wait blocks execution and re-checks pins every clock
// - pin wait gates core execution activity to cut its power
// - pin-equal already true at start releases without extra pause
// - video wait stalls until generator ready, then hands over operands
// - video wait samples generator ready every clock, execution gated
// - colour word holds four byte entries, or two in low half
// - pixel word is sixteen 2-bit or thirty-two 1-bit pixels
// - vga colour entry top six bits are rgb, low two ignored
// - generator takes one operand pair per frame set by scale register
package cwpvu_pkg;
  localparam int CWPVU_ADDR_W = 8;
  localparam int CWPVU_DATA_W = 32;
  localparam int CWPVU_FIFO_DEPTH = 32;
  localparam int CWPVU_VID_W = 64;
  typedef logic [CWPVU_DATA_W-1:0] cwpvu_word_t;
  typedef logic [CWPVU_ADDR_W-1:0] cwpvu_addr_t;
  typedef logic [CWPVU_VID_W-1:0] cwpvu_vid_t;

  // byte offsets
  localparam cwpvu_addr_t CWPVU_OFF_CMD = 8'h00;
  localparam cwpvu_addr_t CWPVU_OFF_STATUS = 8'h04;
  localparam cwpvu_addr_t CWPVU_OFF_STATE = 8'h08;
  localparam cwpvu_addr_t CWPVU_OFF_MASK = 8'h0c;
  localparam cwpvu_addr_t CWPVU_OFF_COLOURS = 8'h10;
  localparam cwpvu_addr_t CWPVU_OFF_PIXELS = 8'h14;
  localparam cwpvu_addr_t CWPVU_OFF_VCTRL = 8'h18;
  localparam cwpvu_addr_t CWPVU_OFF_VSCALE = 8'h1c;
  localparam cwpvu_addr_t CWPVU_OFF_PINS = 8'h20;

  // command register fields
  localparam int CWPVU_CMD_MODE_LSB = 0;
  localparam int CWPVU_CMD_MODE_W = 2;
  localparam int CWPVU_CMD_PORT_BIT = 2;
  localparam int CWPVU_CMD_ABORT_BIT = 3;
  localparam logic [1:0] CWPVU_MODE_NONE = 2'h0;
  localparam logic [1:0] CWPVU_MODE_PEQ = 2'h1;
  localparam logic [1:0] CWPVU_MODE_PNE = 2'h2;
  localparam logic [1:0] CWPVU_MODE_VID = 2'h3;

  // status register fields
  localparam int CWPVU_ST_BUSY_BIT = 0;
  localparam int CWPVU_ST_PIN_BIT = 1;
  localparam int CWPVU_ST_VID_BIT = 2;
  localparam int CWPVU_ST_FIFO_BIT = 3;

  // video control fields
  localparam int CWPVU_VC_GEN_EN_BIT = 0;
  localparam int CWPVU_VC_CTR_EN_BIT = 1;
  localparam int CWPVU_VC_DEPTH_BIT = 2;
  localparam logic [2:0] CWPVU_VCTRL_RST = 3'h0;

  // video scale fields: frame period low, pixel period above
  localparam int CWPVU_FRAME_LSB = 0;
  localparam int CWPVU_FRAME_W = 12;
  localparam int CWPVU_PIXEL_LSB = 12;
  localparam int CWPVU_PIXEL_W = 8;
  localparam int CWPVU_VSCALE_W = 20;
  localparam logic [CWPVU_VSCALE_W-1:0] CWPVU_VSCALE_RST = 20'ha0a00;

  localparam cwpvu_word_t CWPVU_WORD_ZERO = 32'h0000_0000;
  localparam int CWPVU_ENTRY_W = 8;
  localparam int CWPVU_RGB_LSB = 2;
endpackage

// file: core/cwpvu_stream_if.sv
// valid/ready stream carrying one colour and pixel word pair
// assumes both ends share the system clock
`timescale 1ns/1ps
interface cwpvu_stream_if;
  logic valid;
  logic ready;
  cwpvu_pkg::cwpvu_vid_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: core/cwpvu_fifo.sv
// synchronous fifo between the wait unit and the video generator
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module cwpvu_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  // system
  input wire logic clk_i,
  input wire logic rst_n_i,
  // streams
  cwpvu_stream_if.snk in_if,
  cwpvu_stream_if.src out_if
);
  import cwpvu_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic push, pop, full, empty;

  // extra pointer bit tells full from empty
  assign full = (wptr_r[AW] != rptr_r[AW]) &&
                (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
  assign empty = (wptr_r == rptr_r);
  assign in_if.ready = !full;
  assign out_if.valid = !empty;
  assign out_if.data = mem[rptr_r[AW-1:0]];
  assign push = in_if.valid && !full;
  assign pop = out_if.ready && !empty;

  always_comb begin
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    if (push) begin
      wptr_nxt = wptr_r + 1'b1;
    end
    if (pop) begin
      rptr_nxt = rptr_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_r[AW-1:0]] <= in_if.data;
    end
  end
endmodule

// file: core/cwpvu_top.sv
// core wait unit: pin wait, video handoff wait and the video generator
// assumes an apb master, asynchronous pins and a core that obeys stall
`timescale 1ns/1ps
module cwpvu_top (
  // system
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire cwpvu_pkg::cwpvu_addr_t PADDR_I,
  input wire cwpvu_pkg::cwpvu_word_t PWDATA_I,
  output logic PREADY_O,
  output cwpvu_pkg::cwpvu_word_t PRDATA_O,
  output logic PSLVERR_O,
  // input pins
  input wire cwpvu_pkg::cwpvu_word_t FIRST_PORT_INPUTS_I,
  // core sequencer
  output logic STALL_O,
  output logic EXEC_CLK_EN_O,
  output logic WAIT_DONE_O,
  // video out
  output logic [1:0] VGA_RED_O,
  output logic [1:0] VGA_GREEN_O,
  output logic [1:0] VGA_BLUE_O,
  output logic [7:0] VID_COLOUR_O,
  output logic VID_PIXEL_STROBE_O
);
  import cwpvu_pkg::*;

  typedef enum logic [1:0] {CWPVU_IDLE, CWPVU_PIN_WAIT, CWPVU_VID_WAIT}
    cwpvu_state_t;

  function automatic logic addr_mapped(input cwpvu_addr_t a);
    addr_mapped = (a == CWPVU_OFF_CMD) || (a == CWPVU_OFF_STATUS) ||
                  (a == CWPVU_OFF_STATE) || (a == CWPVU_OFF_MASK) ||
                  (a == CWPVU_OFF_COLOURS) || (a == CWPVU_OFF_PIXELS) ||
                  (a == CWPVU_OFF_VCTRL) || (a == CWPVU_OFF_VSCALE) ||
                  (a == CWPVU_OFF_PINS);
  endfunction

  // masked comparison shared by both pin waits
  function automatic logic pin_match(input cwpvu_word_t pins,
                                     input cwpvu_word_t mask,
                                     input cwpvu_word_t state);
    pin_match = ((pins & mask) == state);
  endfunction

  // pin synchroniser and debounced pin state
  cwpvu_word_t sync1_r, sync2_r, sync3_r, pins_r, pins_nxt;
  // operands and configuration
  cwpvu_word_t state_op_r, state_op_nxt, mask_op_r, mask_op_nxt;
  cwpvu_word_t colours_r, colours_nxt, pixels_r, pixels_nxt;
  logic [2:0] vctrl_r, vctrl_nxt;
  logic [CWPVU_VSCALE_W-1:0] video_scale_reg_r, video_scale_reg_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic port_sel_r, port_sel_nxt;
  cwpvu_state_t st_r, st_nxt;
  logic done_r, done_nxt;
  cwpvu_word_t prdata_r, prdata_nxt;
  logic slverr_r, slverr_nxt;

  logic apb_setup, apb_wr;
  logic gen_en, ctr_en, depth4;
  cwpvu_word_t port_pins;
  logic cond_true, vid_ready;

  cwpvu_stream_if push_if ();
  cwpvu_stream_if pop_if ();

  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I &&
                  addr_mapped(PADDR_I);
  assign gen_en = vctrl_r[CWPVU_VC_GEN_EN_BIT];
  assign ctr_en = vctrl_r[CWPVU_VC_CTR_EN_BIT];
  assign depth4 = vctrl_r[CWPVU_VC_DEPTH_BIT];

  // second port is not built; it reads as all zero
  assign port_pins = port_sel_r ? CWPVU_WORD_ZERO : pins_r;

  // without generator and counter running the handoff never becomes ready
  assign vid_ready = push_if.ready && gen_en && ctr_en;

  always_comb begin
    cond_true = 1'b0;
    unique case (st_r)
      CWPVU_IDLE: cond_true = 1'b0;
      CWPVU_PIN_WAIT: begin
        if (mode_r == CWPVU_MODE_PEQ) begin
          cond_true = pin_match(port_pins, mask_op_r, state_op_r);
        end else begin
          cond_true = !pin_match(port_pins, mask_op_r, state_op_r);
        end
      end
      CWPVU_VID_WAIT: cond_true = vid_ready;
    endcase
  end

  // operands handed to the generator in the cycle ready is seen
  assign push_if.valid = (st_r == CWPVU_VID_WAIT) && vid_ready;
  assign push_if.data = {colours_r, pixels_r};

  // stall and execution gate follow the wait state directly
  assign STALL_O = (st_r != CWPVU_IDLE);
  assign EXEC_CLK_EN_O = (st_r == CWPVU_IDLE);
  assign WAIT_DONE_O = done_r;
  assign PREADY_O = 1'b1;
  assign PRDATA_O = prdata_r;
  assign PSLVERR_O = slverr_r && PSEL_I && PENABLE_I;

  // pins count as changed once second and third stages agree
  always_comb begin
    for (int i = 0; i < CWPVU_DATA_W; i++) begin
      pins_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync2_r[i] : pins_r[i];
    end
  end

  // wait sequencer and operand registers
  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    port_sel_nxt = port_sel_r;
    state_op_nxt = state_op_r;
    mask_op_nxt = mask_op_r;
    colours_nxt = colours_r;
    pixels_nxt = pixels_r;
    vctrl_nxt = vctrl_r;
    video_scale_reg_nxt = video_scale_reg_r;
    done_nxt = 1'b0;
    unique case (st_r)
      CWPVU_IDLE: begin
        if (apb_wr) begin
          unique case (PADDR_I)
            CWPVU_OFF_STATE: state_op_nxt = PWDATA_I;
            CWPVU_OFF_MASK: mask_op_nxt = PWDATA_I;
            CWPVU_OFF_COLOURS: colours_nxt = PWDATA_I;
            CWPVU_OFF_PIXELS: pixels_nxt = PWDATA_I;
            CWPVU_OFF_CMD: begin
              mode_nxt = PWDATA_I[CWPVU_CMD_MODE_LSB +: CWPVU_CMD_MODE_W];
              port_sel_nxt = PWDATA_I[CWPVU_CMD_PORT_BIT];
              if (mode_nxt == CWPVU_MODE_VID) begin
                st_nxt = CWPVU_VID_WAIT;
              end else if (mode_nxt != CWPVU_MODE_NONE) begin
                st_nxt = CWPVU_PIN_WAIT;
              end
            end
            default: ;
          endcase
        end
      end
      CWPVU_PIN_WAIT, CWPVU_VID_WAIT: begin
        // one cycle from first true compare to release, even at start
        if (cond_true) begin
          st_nxt = CWPVU_IDLE;
          done_nxt = 1'b1;
        end else if (apb_wr && (PADDR_I == CWPVU_OFF_CMD) &&
                     PWDATA_I[CWPVU_CMD_ABORT_BIT]) begin
          // escape for a wait that can never finish
          st_nxt = CWPVU_IDLE;
        end
      end
    endcase
    // generator enables stay writable so a hung video wait can be fixed; scale only in idle
    if (apb_wr && (PADDR_I == CWPVU_OFF_VCTRL)) begin
      vctrl_nxt = PWDATA_I[2:0];
    end
    if (apb_wr && (PADDR_I == CWPVU_OFF_VSCALE) && (st_r == CWPVU_IDLE)) begin
      video_scale_reg_nxt = PWDATA_I[CWPVU_VSCALE_W-1:0];
    end
  end

  // read data is captured in the setup phase, zero wait states
  always_comb begin
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    if (apb_setup) begin
      prdata_nxt = CWPVU_WORD_ZERO;
      slverr_nxt = !addr_mapped(PADDR_I);
      if (!PWRITE_I) begin
        unique case (PADDR_I)
          CWPVU_OFF_CMD: begin
            prdata_nxt[CWPVU_CMD_MODE_LSB +: CWPVU_CMD_MODE_W] = mode_r;
            prdata_nxt[CWPVU_CMD_PORT_BIT] = port_sel_r;
          end
          CWPVU_OFF_STATUS: begin
            prdata_nxt[CWPVU_ST_BUSY_BIT] = (st_r != CWPVU_IDLE);
            prdata_nxt[CWPVU_ST_PIN_BIT] = (st_r == CWPVU_PIN_WAIT);
            prdata_nxt[CWPVU_ST_VID_BIT] = (st_r == CWPVU_VID_WAIT);
            prdata_nxt[CWPVU_ST_FIFO_BIT] = push_if.ready;
          end
          CWPVU_OFF_STATE: prdata_nxt = state_op_r;
          CWPVU_OFF_MASK: prdata_nxt = mask_op_r;
          CWPVU_OFF_COLOURS: prdata_nxt = colours_r;
          CWPVU_OFF_PIXELS: prdata_nxt = pixels_r;
          CWPVU_OFF_VCTRL: prdata_nxt[2:0] = vctrl_r;
          CWPVU_OFF_VSCALE: prdata_nxt[CWPVU_VSCALE_W-1:0] = video_scale_reg_r;
          CWPVU_OFF_PINS: prdata_nxt = pins_r;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      sync1_r <= CWPVU_WORD_ZERO;
      sync2_r <= CWPVU_WORD_ZERO;
      sync3_r <= CWPVU_WORD_ZERO;
      pins_r <= CWPVU_WORD_ZERO;
      st_r <= CWPVU_IDLE;
      mode_r <= CWPVU_MODE_NONE;
      port_sel_r <= 1'b0;
      state_op_r <= CWPVU_WORD_ZERO;
      mask_op_r <= CWPVU_WORD_ZERO;
      colours_r <= CWPVU_WORD_ZERO;
      pixels_r <= CWPVU_WORD_ZERO;
      vctrl_r <= CWPVU_VCTRL_RST;
      video_scale_reg_r <= CWPVU_VSCALE_RST;
      done_r <= 1'b0;
      prdata_r <= CWPVU_WORD_ZERO;
      slverr_r <= 1'b0;
    end else begin
      sync1_r <= FIRST_PORT_INPUTS_I;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pins_r <= pins_nxt;
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      port_sel_r <= port_sel_nxt;
      state_op_r <= state_op_nxt;
      mask_op_r <= mask_op_nxt;
      colours_r <= colours_nxt;
      pixels_r <= pixels_nxt;
      vctrl_r <= vctrl_nxt;
      video_scale_reg_r <= video_scale_reg_nxt;
      done_r <= done_nxt;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  cwpvu_fifo #(
    .WIDTH(CWPVU_VID_W),
    .DEPTH(CWPVU_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RSTN_I),
    .in_if(push_if),
    .out_if(pop_if)
  );

  // video generator: frame counter, pixel counter, shift register
  logic [CWPVU_FRAME_W-1:0] frame_cnt_r, frame_cnt_nxt, frame_period_count;
  logic [CWPVU_PIXEL_W-1:0] pix_cnt_r, pix_cnt_nxt, pixel_period_count;
  cwpvu_word_t shift_r, shift_nxt, pal_r, pal_nxt;
  logic [7:0] colour_r, colour_nxt;
  logic strobe_r, strobe_nxt;
  logic run, frame_end, pix_end;
  logic [1:0] pix_idx;

  assign frame_period_count = video_scale_reg_r[CWPVU_FRAME_LSB +:
                                                CWPVU_FRAME_W];
  assign pixel_period_count = video_scale_reg_r[CWPVU_PIXEL_LSB +:
                                                CWPVU_PIXEL_W];
  assign run = gen_en && ctr_en;
  assign frame_end = run && (frame_cnt_r == '0);
  assign pix_end = run && (pix_cnt_r == '0);
  // one operand pair per frame; an empty fifo keeps the palette and the shifted-out pixel word
  assign pop_if.ready = frame_end;
  // four-colour uses 2-bit pixels, two-colour uses the low bit only
  assign pix_idx = depth4 ? shift_r[1:0] : {1'b0, shift_r[0]};

  always_comb begin
    frame_cnt_nxt = frame_cnt_r;
    pix_cnt_nxt = pix_cnt_r;
    shift_nxt = shift_r;
    pal_nxt = pal_r;
    colour_nxt = colour_r;
    strobe_nxt = 1'b0;
    if (!run) begin
      frame_cnt_nxt = '0;
      pix_cnt_nxt = '0;
    end else begin
      if (frame_end) begin
        frame_cnt_nxt = frame_period_count - 1'b1;
        pix_cnt_nxt = pixel_period_count - 1'b1;
        if (pop_if.valid) begin
          pal_nxt = pop_if.data[CWPVU_VID_W-1 -: CWPVU_DATA_W];
          shift_nxt = pop_if.data[CWPVU_DATA_W-1:0];
        end
      end else begin
        frame_cnt_nxt = frame_cnt_r - 1'b1;
        if (pix_end) begin
          pix_cnt_nxt = pixel_period_count - 1'b1;
          shift_nxt = depth4 ? (shift_r >> 2) : (shift_r >> 1);
        end else begin
          pix_cnt_nxt = pix_cnt_r - 1'b1;
        end
      end
      if (pix_end) begin
        colour_nxt = pal_r[pix_idx * CWPVU_ENTRY_W +: CWPVU_ENTRY_W];
        strobe_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      frame_cnt_r <= '0;
      pix_cnt_r <= '0;
      shift_r <= CWPVU_WORD_ZERO;
      pal_r <= CWPVU_WORD_ZERO;
      colour_r <= 8'h00;
      strobe_r <= 1'b0;
    end else begin
      frame_cnt_r <= frame_cnt_nxt;
      pix_cnt_r <= pix_cnt_nxt;
      shift_r <= shift_nxt;
      pal_r <= pal_nxt;
      colour_r <= colour_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  // vga takes the top six bits of an entry; the low two are unused
  assign VGA_RED_O = colour_r[CWPVU_RGB_LSB + 4 +: 2];
  assign VGA_GREEN_O = colour_r[CWPVU_RGB_LSB + 2 +: 2];
  assign VGA_BLUE_O = colour_r[CWPVU_RGB_LSB +: 2];
  assign VID_COLOUR_O = colour_r;
  assign VID_PIXEL_STROBE_O = strobe_r;
endmodule

// file: sim/cwpvu_props.sv
// concurrent checks on the ports of the core wait unit
// assumes a bind to cwpvu_top; one clock domain, synchronous reset
`timescale 1ns/1ps
module cwpvu_props (
  // system
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // apb
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire cwpvu_pkg::cwpvu_addr_t PADDR_I,
  input wire cwpvu_pkg::cwpvu_word_t PWDATA_I,
  input wire cwpvu_pkg::cwpvu_word_t PRDATA_O,
  input wire logic PSLVERR_O,
  // core and video
  input wire logic STALL_O,
  input wire logic EXEC_CLK_EN_O,
  input wire logic WAIT_DONE_O,
  input wire logic [1:0] VGA_RED_O,
  input wire logic [1:0] VGA_GREEN_O,
  input wire logic [1:0] VGA_BLUE_O,
  input wire logic [7:0] VID_COLOUR_O
);
  import cwpvu_pkg::*;
  logic acc;
  logic cmd_wr;
  assign acc = PSEL_I && PENABLE_I;
  assign cmd_wr = acc && PWRITE_I && PADDR_I == CWPVU_OFF_CMD;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  property p_gate;
    EXEC_CLK_EN_O == !STALL_O;
  endproperty
  a_gate: assert property (p_gate)
    else $error("execution enable not inverse of stall");
  property p_start;
    cmd_wr && !STALL_O && PWDATA_I[1:0] != CWPVU_MODE_NONE
      && !PWDATA_I[CWPVU_CMD_ABORT_BIT] |=> STALL_O;
  endproperty
  a_start: assert property (p_start)
    else $error("wait command did not stall");
  property p_done_pulse;
    WAIT_DONE_O |=> !WAIT_DONE_O;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_done_cause;
    WAIT_DONE_O |-> !STALL_O && $past(STALL_O);
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("done without a stall ending");
  property p_abort;
    cmd_wr && STALL_O && PWDATA_I[CWPVU_CMD_ABORT_BIT]
      |=> !STALL_O && !WAIT_DONE_O;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not end wait quietly");
  property p_vga;
    VGA_RED_O == VID_COLOUR_O[7:6] && VGA_GREEN_O == VID_COLOUR_O[5:4]
      && VGA_BLUE_O == VID_COLOUR_O[3:2];
  endproperty
  a_vga: assert property (p_vga)
    else $error("vga fields not from colour entry");
  property p_err;
    acc && PADDR_I > CWPVU_OFF_PINS |-> PSLVERR_O;
  endproperty
  a_err: assert property (p_err)
    else $error("unmapped access without error");
  property p_rdhold;
    acc |=> $stable(PRDATA_O);
  endproperty
  a_rdhold: assert property (p_rdhold)
    else $error("read data moved after access");
endmodule

bind cwpvu_top cwpvu_props u_props (
  .CLK_SYS_I(CLK_SYS_I),
  .RSTN_I(RSTN_I),
  .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O),
  .PSLVERR_O(PSLVERR_O),
  .STALL_O(STALL_O),
  .EXEC_CLK_EN_O(EXEC_CLK_EN_O),
  .WAIT_DONE_O(WAIT_DONE_O),
  .VGA_RED_O(VGA_RED_O),
  .VGA_GREEN_O(VGA_GREEN_O),
  .VGA_BLUE_O(VGA_BLUE_O),
  .VID_COLOUR_O(VID_COLOUR_O)
);

// file: sim/cwpvu_pins_model.sv
// stand-in for the external driver of the first input port
// assumes the bench sets the wanted pattern; pins move after an edge
`timescale 1ns/1ps
module cwpvu_pins_model (
  // system
  input wire logic clk_i,
  // control
  input wire cwpvu_pkg::cwpvu_word_t want_i,
  // pins
  output cwpvu_pkg::cwpvu_word_t pins_o
);
  import cwpvu_pkg::*;
  // pins are asynchronous to the unit; moving them on the rising edge is enough
  always_ff @(posedge clk_i) begin
    pins_o <= want_i;
  end
endmodule

// file: sim/tb.sv
// self-checking bench for the core wait unit
// assumes cwpvu_top with its checker bound and a pin model on the port
`timescale 1ns/1ps
module tb;
  import cwpvu_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  cwpvu_addr_t paddr = 8'h00;
  cwpvu_word_t pwdata = 32'h0;
  cwpvu_word_t want = 32'h0;
  cwpvu_word_t pins;
  cwpvu_word_t prdata;
  cwpvu_word_t rd;
  logic pready;
  logic pslverr;
  logic err;
  logic stall;
  logic run_en;
  logic done;
  logic strobe;
  logic [1:0] red;
  logic [1:0] grn;
  logic [1:0] blu;
  logic [7:0] colour;
  int mismatches = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  cwpvu_pins_model pins_m (.clk_i(clk), .want_i(want), .pins_o(pins));
  cwpvu_top dut (
    .CLK_SYS_I(clk),
    .RSTN_I(rst_n),
    .PSEL_I(psel),
    .PENABLE_I(pen),
    .PWRITE_I(pwr),
    .PADDR_I(paddr),
    .PWDATA_I(pwdata),
    .PREADY_O(pready),
    .PRDATA_O(prdata),
    .PSLVERR_O(pslverr),
    .FIRST_PORT_INPUTS_I(pins),
    .STALL_O(stall),
    .EXEC_CLK_EN_O(run_en),
    .WAIT_DONE_O(done),
    .VGA_RED_O(red),
    .VGA_GREEN_O(grn),
    .VGA_BLUE_O(blu),
    .VID_COLOUR_O(colour),
    .VID_PIXEL_STROBE_O(strobe)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // the idle edge up front keeps two transfers from driving one step
  task automatic apb(input logic w, input cwpvu_addr_t a,
                     input cwpvu_word_t d);
    logic ok;
    int n;
    ok = 1'b0;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // request stands until pready is seen high at a rising edge
    while (!ok && n < 100) begin
      @(posedge clk);
      ok = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
      n++;
    end
    check(ok, 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input cwpvu_addr_t a, input cwpvu_word_t d);
    apb(1'b1, a, d);
  endtask

  task automatic rdr(input cwpvu_addr_t a);
    apb(1'b0, a, 32'h0);
  endtask

  // counts stalled cycles; ends in the first idle cycle or once lim stalled cycles are counted
  task automatic wait_rel(input int lim, output int c);
    c = 0;
    @(negedge clk);
    while (stall === 1'b1 && c < lim) begin
      c++;
      @(negedge clk);
    end
  endtask

  task automatic next_strobe(input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (strobe !== 1'b1 && n < lim);
  endtask

  task automatic t_regs();
    rdr(CWPVU_OFF_VSCALE);
    check(rd, 32'h000a0a00);
    rdr(CWPVU_OFF_VCTRL);
    check(rd, 32'h0);
    wr(CWPVU_OFF_MASK, 32'h0000000c);
    rdr(CWPVU_OFF_MASK);
    check(rd, 32'h0000000c);
    rdr(8'h40);
    check(err, 1'b1);
    check(rd, 32'h0);
    $display("regs test done");
  endtask

  task automatic t_peq();
    int c;
    wr(CWPVU_OFF_STATE, 32'h00000004);
    repeat (8) @(posedge clk);
    wr(CWPVU_OFF_CMD, 32'h1);
    wr(CWPVU_OFF_STATE, 32'h0);
    wait_rel(20, c);
    check(c, 20);
    @(posedge clk);
    want <= 32'hfffffff4;
    wait_rel(20, c);
    check(c >= 2 && c <= 8, 1'b1);
    check(done, 1'b1);
    wr(CWPVU_OFF_CMD, 32'h1);
    wait_rel(5, c);
    check(c, 1);
    check(done, 1'b1);
    $display("pin equal test done");
  endtask

  task automatic t_pne();
    int c;
    wr(CWPVU_OFF_CMD, 32'h2);
    @(posedge clk);
    want <= 32'h00000004;
    wait_rel(12, c);
    check(c, 12);
    @(posedge clk);
    want <= 32'h0;
    wait_rel(20, c);
    check(c >= 2 && c <= 8, 1'b1);
    check(done, 1'b1);
    $display("pin differ test done");
  endtask

  task automatic t_port();
    int c;
    @(posedge clk);
    want <= 32'h00000004;
    repeat (8) @(posedge clk);
    wr(CWPVU_OFF_CMD, 32'h5);
    wait_rel(12, c);
    check(c, 12);
    wr(CWPVU_OFF_CMD, 32'h8);
    wait_rel(5, c);
    check(c, 0);
    check(done, 1'b0);
    wr(CWPVU_OFF_CMD, 32'h6);
    wait_rel(5, c);
    check(c, 1);
    $display("port select test done");
  endtask

  task automatic t_vid();
    int c;
    int idx;
    wr(CWPVU_OFF_COLOURS, 32'h112233e4);
    wr(CWPVU_OFF_PIXELS, 32'h000000e4);
    wr(CWPVU_OFF_VSCALE, 32'h00004fff);
    wr(CWPVU_OFF_CMD, 32'h3);
    wait_rel(30, c);
    check(c, 30);
    wr(CWPVU_OFF_VCTRL, 32'h7);
    wait_rel(10, c);
    check(stall, 1'b0);
    check(done, 1'b1);
    // one frame is far longer than 32 handoffs, so the buffer fills
    for (int i = 0; i < 32; i++) begin
      wr(CWPVU_OFF_CMD, 32'h3);
      wait_rel(5000, c);
    end
    // last handoff waited for the frame start that loaded the first pair
    for (int k = 0; k < 4; k++) begin
      next_strobe(8, c);
      check(colour, (32'h112233e4 >> (8 * k)) & 32'hff);
    end
    rdr(CWPVU_OFF_STATUS);
    check(rd[CWPVU_ST_FIFO_BIT], 1'b0);
    wr(CWPVU_OFF_CMD, 32'h3);
    wait_rel(100, c);
    check(c, 100);
    wr(CWPVU_OFF_CMD, 32'h8);
    next_strobe(5000, c);
    for (int k = 0; k < 6; k++) begin
      check(colour, 32'he4);
      check({red, grn, blu}, 32'h39);
      next_strobe(50, c);
      check(c, 4);
    end
    // two-colour mode: 1-bit pixels pick one of the low two entries
    wr(CWPVU_OFF_VCTRL, 32'h3);
    wr(CWPVU_OFF_CMD, 32'h3);
    wait_rel(5000, c);
    for (int k = 0; k < 8; k++) begin
      next_strobe(8, c);
      idx = (32'he4 >> k) & 1;
      check(colour, (32'h112233e4 >> (8 * idx)) & 32'hff);
    end
    $display("video test done");
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_peq();
    t_pne();
    t_port();
    t_vid();
    end_of_test();
  end
endmodule
